/* rtl/timer2_core.v */
// timer2_core.v: 16-bit timer/counter with reload, capture, auto-zero and split mode
// assumes tick inputs are one-cycle pulses synchronous to sys_clk; software
// flag clears arrive as one-cycle pulses; all control bits are plain ports
//
// Overview of operation
// - 16-bit counter, timer ticks or external events
// - mode chosen by control and mode bits
// - mode 0 reloads on overflow, flag interrupt blockable
// - falling edge enable sets external event flag
// - rising edge enable does same on rise
// - external input picked from eight candidates
// - each 16-bit overflow pulses the exported event
// - mode 1 counts to ffff, reloads, flags
// - mode 1 enabled edge also reloads, flags
// - either flag requests the shared interrupt
// - mode 2 edge captures count, flags
// - mode 3 capture edge also zeroes count
// - split: two 8-bit counters with reloads
// - split runs separate; auto-stop clears low run
// - split rollovers set high and low flags
// - split flags only cleared by software
// - split export follows low byte overflow
// - bit select maps control bits 5,4
// - split mode 1 mirrors mode 1
module timer2_core #(
  parameter NUM_EXT = 8
) (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [NUM_EXT-1:0] ext_inputs,
  input wire [2:0] ext_select,
  input wire [7:0] high_src_ticks,
  input wire [2:0] high_src_select,
  input wire [3:0] low_src_ticks,
  input wire [1:0] low_src_select,
  input wire timer_tick,
  input wire counter_tick,
  input wire timer_counter_select,
  input wire [1:0] mode_select,
  input wire main_run,
  input wire low_run_set,
  input wire low_run_clear,
  input wire low_run_auto_stop,
  input wire split_enable,
  input wire ext_fall_enable,
  input wire ext_rise_enable,
  input wire overflow_irq_block,
  input wire irq_enable,
  input wire bit_function_select,
  input wire ctrl_bit5_wdata,
  input wire ctrl_bit4_wdata,
  input wire ctrl_bits_wr,
  input wire overflow_flag_clear,
  input wire ext_event_flag_clear,
  input wire count_wr,
  input wire [15:0] count_wdata,
  input wire reload_wr,
  input wire [15:0] reload_wdata,
  output reg [7:0] count_high,
  output reg [7:0] count_low,
  output reg [7:0] reload_capture_high,
  output reg [7:0] reload_capture_low,
  output reg overflow_flag,
  output reg ext_event_flag,
  output reg low_overflow_flag,
  output reg low_run,
  output reg rx_baud_select,
  output reg tx_baud_select,
  output reg low_overflow_irq_enable,
  output reg overflow_event_out,
  output reg low_overflow_event_out,
  output reg irq_r
);
`include "timer2_defines.vh"

  ////////////////////////////////////////////////////////////////////////////
  // external trigger selection and edge detection

  wire selected_ext_input;
  wire ext_rise;
  wire ext_fall;

  assign selected_ext_input = ext_inputs[ext_select];

  edge_sync u_edge_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .din(selected_ext_input),
    .rise_r(ext_rise),
    .fall_r(ext_fall)
  );

  wire ext_event_set;
  assign ext_event_set = (ext_fall_enable & ext_fall)
                       | (ext_rise_enable & ext_rise);

  ////////////////////////////////////////////////////////////////////////////
  // count sources

  // indexed eight-way mux function, shared by high and low clock choices
  function pick8;
    input [7:0] v;
    input [2:0] s;
    begin
      pick8 = v[s];
    end
  endfunction

  wire word_tick;
  wire high_tick;
  wire low_tick;
  assign word_tick = timer_counter_select ? counter_tick : timer_tick;
  assign high_tick = pick8(high_src_ticks, high_src_select);
  assign low_tick = pick8({4'h0, low_src_ticks}, {1'b0, low_src_select});

  wire [15:0] count_word;
  assign count_word = {count_high, count_low};

  // mode code compare, shared by the reload, capture and zero paths
  function mode_is;
    input [1:0] m;
    input [1:0] code;
    begin
      mode_is = (m == code);
    end
  endfunction

  wire is_reload_mode;
  wire is_capture_mode;
  assign is_reload_mode = mode_is(mode_select, `T2_MODE_AR_EXT)
                        | mode_is(mode_select, `T2_MODE_AR_TRIG);
  assign is_capture_mode = ~is_reload_mode;

  ////////////////////////////////////////////////////////////////////////////
  // overflow and edge actions

  wire word_inc;
  wire word_ovf;
  wire high_inc;
  wire high_ovf;
  wire low_inc;
  wire low_ovf;
  wire edge_reload;
  wire edge_capture;
  wire edge_zero;

  assign word_inc = ~split_enable & main_run & word_tick;
  assign word_ovf = word_inc & (count_word == `T2_WORD_MAX);
  assign high_inc = split_enable & main_run & high_tick;
  assign high_ovf = high_inc & (count_high == `T2_BYTE_MAX);
  assign low_inc = split_enable & low_run & low_tick;
  assign low_ovf = low_inc & (count_low == `T2_BYTE_MAX);

  // mode 0 edges only flag; mode 1 edges also reload
  assign edge_reload = ext_event_set & mode_is(mode_select, `T2_MODE_AR_TRIG);
  assign edge_capture = ext_event_set & is_capture_mode;
  assign edge_zero = ext_event_set & mode_is(mode_select, `T2_MODE_CAP_ZERO);

  ////////////////////////////////////////////////////////////////////////////
  // counter and reload/capture registers

  reg [7:0] count_high_nxt;
  reg [7:0] count_low_nxt;

  // priority: software write, then edge action, then overflow reload, then count
  always @* begin
    count_high_nxt = count_high;
    count_low_nxt = count_low;
    if (count_wr) begin
      count_high_nxt = count_wdata[15:8];
      count_low_nxt = count_wdata[7:0];
    end else if (!split_enable) begin
      if (edge_zero) begin
        count_high_nxt = 8'h00;
        count_low_nxt = 8'h00;
      end else if (edge_reload || (word_ovf && is_reload_mode)) begin
        count_high_nxt = reload_capture_high;
        count_low_nxt = reload_capture_low;
      end else if (word_inc) begin
        {count_high_nxt, count_low_nxt} = count_word + 16'h0001;
      end
    end else begin
      // split halves: high keeps the mode behaviour, low reloads on rollover
      if (edge_zero) begin
        count_high_nxt = 8'h00;
      end else if (edge_reload || (high_ovf && is_reload_mode)) begin
        count_high_nxt = reload_capture_high;
      end else if (high_inc) begin
        count_high_nxt = count_high + 8'h01;
      end
      if (low_ovf) begin
        count_low_nxt = reload_capture_low;
      end else if (low_inc) begin
        count_low_nxt = count_low + 8'h01;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      {count_high, count_low} <= `T2_COUNT_RST;
      {reload_capture_high, reload_capture_low} <= `T2_RELOAD_RST;
    end else if (clk_en) begin
      count_high <= count_high_nxt;
      count_low <= count_low_nxt;
      if (edge_capture) begin
        reload_capture_high <= count_high;
        if (!split_enable) begin
          reload_capture_low <= count_low;
        end
      end else if (reload_wr) begin
        reload_capture_high <= reload_wdata[15:8];
        reload_capture_low <= reload_wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, run control and control-bit sharing

  wire ovf_set;
  assign ovf_set = split_enable ? high_ovf : word_ovf;

  reg overflow_flag_nxt;
  reg ext_event_flag_nxt;
  reg low_overflow_flag_nxt;
  reg low_run_nxt;

  // hardware only sets the flags; a set in the same cycle as a clear wins,
  // so an event that lands on a software clear is never lost
  always @* begin
    overflow_flag_nxt = ovf_set | (overflow_flag & ~overflow_flag_clear);
    ext_event_flag_nxt = ext_event_set | (ext_event_flag & ~ext_event_flag_clear);
    if (ctrl_bits_wr && bit_function_select) begin
      // a write of bit 5 is the only path that lowers this flag
      low_overflow_flag_nxt = low_ovf | ctrl_bit5_wdata;
    end else begin
      low_overflow_flag_nxt = low_overflow_flag | low_ovf;
    end
    // auto-stop outranks a simultaneous software start
    if (split_enable && high_ovf && low_run_auto_stop) begin
      low_run_nxt = 1'b0;
    end else if (low_run_set) begin
      low_run_nxt = 1'b1;
    end else if (low_run_clear) begin
      low_run_nxt = 1'b0;
    end else begin
      low_run_nxt = low_run;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
      ext_event_flag <= 1'b0;
      low_overflow_flag <= 1'b0;
      low_overflow_irq_enable <= 1'b0;
      rx_baud_select <= 1'b0;
      tx_baud_select <= 1'b0;
      low_run <= 1'b0;
    end else if (clk_en) begin
      overflow_flag <= overflow_flag_nxt;
      ext_event_flag <= ext_event_flag_nxt;
      low_overflow_flag <= low_overflow_flag_nxt;
      low_run <= low_run_nxt;
      // bits 5 and 4 share one write port, steered by the function select
      if (ctrl_bits_wr && bit_function_select) begin
        low_overflow_irq_enable <= ctrl_bit4_wdata;
      end
      if (ctrl_bits_wr && !bit_function_select) begin
        rx_baud_select <= ctrl_bit5_wdata;
        tx_baud_select <= ctrl_bit4_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exported events and interrupt request

  reg irq_nxt;

  // irq follows registered flags, so it lags a flag by one cycle; the low flag
  // only counts in split mode, where its enable bit has a meaning
  always @* begin
    irq_nxt = (overflow_flag & ~overflow_irq_block) | ext_event_flag;
    if (split_enable && low_overflow_irq_enable) begin
      irq_nxt = irq_nxt | low_overflow_flag;
    end
    irq_nxt = irq_nxt & irq_enable;
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      overflow_event_out <= 1'b0;
      low_overflow_event_out <= 1'b0;
      irq_r <= 1'b0;
    end else if (clk_en) begin
      overflow_event_out <= split_enable ? low_ovf : word_ovf;
      low_overflow_event_out <= low_ovf;
      irq_r <= irq_nxt;
    end
  end
endmodule // timer2_core

/* rtl/timer2_defines.vh */
// timer2_defines.vh: mode codes, widths and reset values for the split-capable timer
// assumes inclusion by bare name from the timer design files
`ifndef TIMER2_DEFINES_VH
`define TIMER2_DEFINES_VH
`define T2_MODE_AR_EXT 2'h0
`define T2_MODE_AR_TRIG 2'h1
`define T2_MODE_CAPTURE 2'h2
`define T2_MODE_CAP_ZERO 2'h3
`define T2_COUNT_RST 16'h0000
`define T2_RELOAD_RST 16'h0000
`define T2_BYTE_MAX 8'hff
`define T2_WORD_MAX 16'hffff
`define T2_SRC_W 3
`define T2_LSRC_W 2
`endif

/* rtl/edge_sync.v */
// edge_sync.v: two-stage synchroniser with single-cycle rise and fall pulses
// assumes the input is asynchronous-safe level and the clock enable gates all state
module edge_sync (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire din,
  output reg rise_r,
  output reg fall_r
);
  reg meta_r;
  reg sync_r;
  reg prev_r;
  // edges wait until the pipe holds real samples, so a pin idling high
  // gives no false rise right after reset
  reg [2:0] fill_r;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      fill_r <= 3'h0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else if (clk_en) begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= {fill_r[1:0], 1'b1};
      rise_r <= fill_r[2] & sync_r & ~prev_r;
      fall_r <= fill_r[2] & ~sync_r & prev_r;
    end
  end
endmodule // edge_sync

/* tb/timer2_checker.sv */
// timer2_checker.sv: port assertions for the flags, interrupt and event pulses of timer2_core
// assumes only the core's ports; checks pause while clk_en holds the state frozen
module timer2_checker (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire split_enable,
  input wire irq_enable,
  input wire overflow_irq_block,
  input wire overflow_flag_clear,
  input wire ext_event_flag_clear,
  input wire low_run_auto_stop,
  input wire overflow_flag,
  input wire ext_event_flag,
  input wire low_overflow_flag,
  input wire low_run,
  input wire overflow_event_out,
  input wire low_overflow_event_out,
  input wire irq_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !clk_en);
  ////////////////////////////////////////
  a_ovf_evt_flag: assert property (overflow_event_out && !split_enable |-> overflow_flag)
    else $error("overflow event without overflow flag");
  a_irq_follows_flag: assert property ((ext_event_flag || overflow_flag && !overflow_irq_block)
    && irq_enable |=> irq_r) else $error("flag set but no interrupt request");
  a_irq_quiet: assert property (!overflow_flag && !ext_event_flag && !low_overflow_flag |=> !irq_r)
    else $error("interrupt request with no flag");
  a_ovf_blocked: assert property (overflow_irq_block && !ext_event_flag && !low_overflow_flag
    |=> !irq_r) else $error("blocked overflow still requests");
  a_split_ovf_hold: assert property (split_enable && overflow_flag && !overflow_flag_clear
    |=> overflow_flag) else $error("overflow flag dropped by hardware");
  a_split_ext_hold: assert property (split_enable && ext_event_flag && !ext_event_flag_clear
    |=> ext_event_flag) else $error("external flag dropped by hardware");
  a_low_evt_flag: assert property (low_overflow_event_out |-> low_overflow_flag)
    else $error("low event without low flag");
  a_low_auto_stop: assert property (split_enable && low_run_auto_stop && $rose(overflow_flag)
    |-> !low_run) else $error("low run survived high overflow");
  c_overflow: cover property (overflow_event_out);
  c_ext_event: cover property ($rose(ext_event_flag));
  c_low_overflow: cover property (low_overflow_event_out);
endmodule // timer2_checker

bind timer2_core timer2_checker i_chk (.sys_clk, .rst_n, .clk_en, .split_enable, .irq_enable,
  .overflow_irq_block, .overflow_flag_clear, .ext_event_flag_clear, .low_run_auto_stop,
  .overflow_flag, .ext_event_flag, .low_overflow_flag, .low_run, .overflow_event_out,
  .low_overflow_event_out, .irq_r);

/* tb/tb_timer2_core.sv */
// tb_timer2_core.sv: directed self-checking bench for timer2_core
// assumes the checker is bound in; inputs change on the falling edge only
module tb_timer2_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_n = 0, clk_en = 1, timer_tick = 0, counter_tick = 0;
  logic [7:0] ext_inputs = 8'h00, high_src_ticks = 8'h00;
  logic [2:0] ext_select = 3'h5, high_src_select = 3'h0;
  logic [3:0] low_src_ticks = 4'h0;
  logic [1:0] low_src_select = 2'h0, mode_select = 2'h0;
  logic timer_counter_select = 0, main_run = 0, low_run_set = 0, low_run_clear = 0;
  logic low_run_auto_stop = 0, split_enable = 0, ext_fall_enable = 0, ext_rise_enable = 0;
  logic overflow_irq_block = 0, irq_enable = 1, bit_function_select = 0, ctrl_bits_wr = 0;
  logic ctrl_bit5_wdata = 0, ctrl_bit4_wdata = 0, overflow_flag_clear = 0;
  logic ext_event_flag_clear = 0, count_wr = 0, reload_wr = 0;
  logic [15:0] count_wdata = 16'h0000, reload_wdata = 16'h0000;
  wire [7:0] count_high, count_low, reload_capture_high, reload_capture_low;
  wire overflow_flag, ext_event_flag, low_overflow_flag, low_run, rx_baud_select, irq_r;
  wire tx_baud_select, low_overflow_irq_enable, overflow_event_out, low_overflow_event_out;
  int fail_count = 0, total_checks = 0;
  timer2_core i_dut (.sys_clk, .rst_n, .clk_en, .ext_inputs, .ext_select, .high_src_ticks,
    .high_src_select, .low_src_ticks, .low_src_select, .timer_tick, .counter_tick,
    .timer_counter_select, .mode_select, .main_run, .low_run_set, .low_run_clear,
    .low_run_auto_stop, .split_enable, .ext_fall_enable, .ext_rise_enable, .overflow_irq_block,
    .irq_enable, .bit_function_select, .ctrl_bit5_wdata, .ctrl_bit4_wdata, .ctrl_bits_wr,
    .overflow_flag_clear, .ext_event_flag_clear, .count_wr, .count_wdata, .reload_wr,
    .reload_wdata, .count_high, .count_low, .reload_capture_high, .reload_capture_low,
    .overflow_flag, .ext_event_flag, .low_overflow_flag, .low_run, .rx_baud_select,
    .tx_baud_select, .low_overflow_irq_enable, .overflow_event_out, .low_overflow_event_out,
    .irq_r);
  initial forever #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  task automatic chk(input logic ok);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: port value differs from expectation", $time);
    end
  endtask
  task automatic rst();
    @(negedge sys_clk);
    rst_n = 0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1;
    chk({count_high, count_low, reload_capture_low, overflow_flag, irq_r} === 26'h0);
  endtask
  // both words written in one cycle, so counting sees a consistent pair
  task automatic load(input logic [15:0] c, input logic [15:0] r);
    @(negedge sys_clk);
    count_wdata = c;
    reload_wdata = r;
    count_wr = 1;
    reload_wr = 1;
    @(negedge sys_clk);
    count_wr = 0;
    reload_wr = 0;
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reload();
    rst();
    mode_select = 2'h1;
    timer_counter_select = 1;
    load(16'hfffe, 16'hfffe);
    main_run = 1;
    counter_tick = 1;
    @(negedge sys_clk);
    chk({count_high, count_low} === 16'hffff);
    @(negedge sys_clk);
    chk({count_high, count_low, overflow_flag, overflow_event_out} === 18'h3fffb);
    main_run = 0;
    @(negedge sys_clk);
    chk({irq_r, overflow_event_out} === 2'b10);
    overflow_irq_block = 1;
    @(negedge sys_clk);
    chk(irq_r === 1'b0);
    overflow_flag_clear = 1;
    overflow_irq_block = 0;
    @(negedge sys_clk);
    overflow_flag_clear = 0;
    chk(overflow_flag === 1'b0);
    timer_counter_select = 0;
    main_run = 1;
    @(negedge sys_clk);
    chk({count_high, count_low} === 16'hfffe);
    timer_tick = 1;
    @(negedge sys_clk);
    chk({count_high, count_low} === 16'hffff);
    clk_en = 0;
    repeat (3) @(negedge sys_clk);
    chk({count_high, count_low, overflow_flag} === 17'h1fffe);
    clk_en = 1;
    @(negedge sys_clk);
    chk({count_high, count_low, overflow_flag, overflow_event_out} === 18'h3fffb);
    main_run = 0;
    timer_tick = 0;
    $display("reload test done");
  endtask
  task automatic t_capture(input logic [1:0] m, input logic rise);
    int i;
    rst();
    mode_select = m;
    ext_inputs = rise ? 8'h00 : 8'hff;
    ext_fall_enable = ~rise;
    ext_rise_enable = rise;
    load(16'h1234, 16'h5678);
    repeat (4) @(negedge sys_clk);
    ext_inputs[2] = ~ext_inputs[2];
    repeat (6) @(negedge sys_clk);
    chk(ext_event_flag === 1'b0);
    ext_inputs[5] = ~ext_inputs[5];
    for (i = 0; i < 8 && ext_event_flag !== 1'b1; i++) @(negedge sys_clk);
    chk(i == 4);
    chk(ext_event_flag === 1'b1);
    chk({reload_capture_high, reload_capture_low} === (m[1] ? 16'h1234 : 16'h5678));
    chk({count_high, count_low} === (m == 2'h1 ? 16'h5678 : m == 2'h3 ? 16'h0 : 16'h1234));
    $display("capture test done for mode %0d", m);
  endtask
  task automatic t_split();
    int i;
    rst();
    mode_select = 2'h1;
    split_enable = 1;
    ctrl_bit5_wdata = 1;
    ctrl_bits_wr = 1;
    @(negedge sys_clk);
    chk({rx_baud_select, tx_baud_select} === 2'b10);
    bit_function_select = 1;
    ctrl_bit5_wdata = 0;
    ctrl_bit4_wdata = 1;
    @(negedge sys_clk);
    ctrl_bits_wr = 0;
    chk(low_overflow_irq_enable === 1'b1);
    load(16'hfffe, 16'h10f0);
    low_src_select = 2'h2;
    low_src_ticks = 4'h4;
    low_run_set = 1;
    @(negedge sys_clk);
    low_run_set = 0;
    for (i = 0; i < 8 && low_overflow_event_out !== 1'b1; i++) @(negedge sys_clk);
    chk({low_overflow_event_out, overflow_event_out} === 2'b11);
    chk({count_high, count_low, low_overflow_flag} === 17'h1ffe1);
    low_src_ticks = 4'h0;
    low_run_auto_stop = 1;
    high_src_select = 3'h6;
    high_src_ticks = 8'h40;
    main_run = 1;
    for (i = 0; i < 8 && overflow_flag !== 1'b1; i++) @(negedge sys_clk);
    main_run = 0;
    chk({overflow_flag, low_run, count_high} === 10'h210);
    repeat (3) @(negedge sys_clk);
    chk({overflow_flag, low_overflow_flag, irq_r, ext_event_flag} === 4'b1110);
    overflow_flag_clear = 1;
    @(negedge sys_clk);
    overflow_flag_clear = 0;
    @(negedge sys_clk);
    chk({overflow_flag, irq_r} === 2'b01);
    ctrl_bits_wr = 1;
    low_run_set = 1;
    @(negedge sys_clk);
    ctrl_bits_wr = 0;
    low_run_set = 0;
    low_run_clear = 1;
    chk({low_overflow_flag, low_run} === 2'b01);
    @(negedge sys_clk);
    low_run_clear = 0;
    chk({low_run, irq_r} === 2'b00);
    $display("split test done");
  endtask
  ////////////////////////////////////////
  initial begin
    t_reload();
    for (int k = 0; k < 4; k++) t_capture(k[1:0], k[0]);
    t_split();
    end_sim();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
endmodule // tb_timer2_core
